// file: logic/rrf_consts.svh
// Constants for the record builder flow-control block.
`ifndef RRF_CONSTS_SVH
`define RRF_CONSTS_SVH
`define RRF_NUM_INPUTS 12
`define RRF_NUM_AU 4
`define RRF_IB_DEPTH 128
`define RRF_OF_DEPTH 4096
`define RRF_TIMER_W 24
`define RRF_EID_W 24
`define RRF_HDR_NIB 4'hb
`define RRF_TRL_NIB 4'he
`define RRF_REC_NIB 4'hc
`define RRF_OFS_CARD 8'h00
`define RRF_OFS_ACTIVE 8'h04
`define RRF_OFS_TIMEOUT 8'h08
`define RRF_OFS_STATUS 8'h0c
`define RRF_OFS_BUILT 8'h10
`define RRF_CARD_RST 8'h00
`define RRF_ACTIVE_RST 16'h0fff
`define RRF_TIMEOUT_RST 24'h002710
`endif

// file: logic/rrf_pkg.sv
// Types shared by the record builder flow-control logic.
package rrf_pkg;
  typedef logic [31:0] rrf_word_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_DECIDE = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DROP = 2'b11
  } rrf_alloc_st_t;
endpackage

// file: logic/rrf_fifo_if.sv
// Connection between a FIFO and the logic that fills and drains it.
`timescale 1ns/1ps
interface rrf_fifo_if #(parameter int W = 32) ();
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] din;
  logic [W-1:0] dout;
  logic empty;
  logic full;
  modport owner (output push, output pop, output flush, output din,
                 input dout, input empty, input full);
  modport store (input push, input pop, input flush, input din,
                 output dout, output empty, output full);
endinterface

// file: logic/rrf_fifo.sv
// Synchronous show-ahead FIFO used for input buffers and output queues.
`timescale 1ns/1ps
module rrf_fifo
#(
  parameter int W = 32,
  parameter int DEPTH = 128
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Storage port
  rrf_fifo_if.store q
);
  import rrf_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
      $error("FIFO depth must be a power of two");
    end
  endgenerate

  assign q.empty = wr_q == rd_q;
  assign q.full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign q.dout = mem[rd_q[AW-1:0]];

  always_ff @(posedge pclk)
  begin
    if (q.push && !q.full)
      mem[wr_q[AW-1:0]] <= q.din;
  end

  // Flush drops everything at once; a push in the same cycle is lost on purpose.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (q.flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (q.push && !q.full)
        wr_q <= wr_q + 1'b1;
      if (q.pop && !q.empty)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// file: logic/rrf_record_flow.sv
// Fragment allocation, record assembly and flow control for one record builder card.
`timescale 1ns/1ps
`include "rrf_consts.svh"
module rrf_record_flow
#(
  parameter int NI = `RRF_NUM_INPUTS,
  parameter int IB_DEPTH = `RRF_IB_DEPTH,
  parameter int OF_DEPTH = `RRF_OF_DEPTH,
  parameter int TW = `RRF_TIMER_W
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire rrf_pkg::rrf_word_t pwdata,
  output rrf_pkg::rrf_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Fragment streams from the input cards
  input wire logic [NI-1:0] frag_valid,
  input wire rrf_pkg::rrf_word_t [NI-1:0] frag_data,
  output logic [NI-1:0] frag_bp,
  // Supervisor links
  input wire logic [3:0] link_bp,
  output logic [3:0] link_valid,
  output logic [3:0] link_last,
  output rrf_pkg::rrf_word_t [3:0] link_data
);
  import rrf_pkg::*;
  localparam int NAU = `RRF_NUM_AU;
  localparam int EW = `RRF_EID_W;
  localparam int IW = $clog2(NI);
  localparam int IAW = $clog2(IB_DEPTH);

  generate
    if (NI < 2 || NI > 16 || TW < 2)
    begin : g_chk
      $error("Input count must be 2 to 16 and the timer at least 2 bits");
    end
  endgenerate

  function automatic logic is_nib(input rrf_word_t w, input logic [3:0] nib);
    return w[31:28] == nib;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `RRF_OFS_CARD || a == `RRF_OFS_ACTIVE || a == `RRF_OFS_TIMEOUT ||
           a == `RRF_OFS_STATUS || a == `RRF_OFS_BUILT;
  endfunction

  // Pin synchronisers.
  logic [NI-1:0] fv_s1_q;
  logic [NI-1:0] fv_s2_q;
  rrf_word_t [NI-1:0] fd_s1_q;
  rrf_word_t [NI-1:0] fd_s2_q;
  logic [NAU-1:0] lbp_s1_q;
  logic [NAU-1:0] lbp_s2_q;

  // Registers.
  logic [7:0] card_q;
  logic [NI-1:0] active_q;
  logic [TW-1:0] timeout_q;
  rrf_word_t prdata_q;
  rrf_word_t rd_mux;

  // Input buffers.
  rrf_word_t [NI-1:0] ib_dout;
  logic [NI-1:0] ib_empty, ib_full, ib_push, ib_pop, ib_flush, rel;
  logic [NI-1:0] full_d_q, hdr_q, rdy_q, frag_bp_q, hold;
  logic [NI-1:0][EW-1:0] ib_eid_q;

  // Allocator and assembly units.
  rrf_alloc_st_t st_q;
  logic [IW-1:0] sel_q;
  logic [1:0] tgt_q;
  logic [IAW-1:0] cnt_q;
  logic stall_q;
  logic [NAU-1:0] au_busy_q, rec_pend_q, jam, close_gnt, au_done;
  logic [NAU-1:0][EW-1:0] au_eid_q;
  logic [NAU-1:0][NI-1:0] au_mask_q;
  logic [NAU-1:0][TW-1:0] au_tmr_q;
  logic [EW-1:0] built_max_q;
  logic built_v_q;
  logic [EW-1:0] cur_eid;
  logic [1:0] pref, match_au, free_au, idx;
  logic match_hit, free_hit, drop, shift_pop, shift_last;
  logic [3:0] cmask;

  // Output FIFOs and link transmitters.
  logic [NAU-1:0][32:0] of_dout;
  logic [NAU-1:0][32:0] of_din;
  logic [NAU-1:0] of_empty, of_full, of_push, tx_go, sending_q;
  logic [NAU-1:0] lv_q, ll_q;
  rrf_word_t [NAU-1:0] ld_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fv_s1_q <= '0;
      fv_s2_q <= '0;
      fd_s1_q <= '0;
      fd_s2_q <= '0;
      lbp_s1_q <= '0;
      lbp_s2_q <= '0;
    end
    else
    begin
      fv_s1_q <= frag_valid;
      fv_s2_q <= fv_s1_q;
      fd_s1_q <= frag_data;
      fd_s2_q <= fd_s1_q;
      lbp_s1_q <= link_bp;
      lbp_s2_q <= lbp_s1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_ib
      rrf_fifo_if #(.W(32)) ibf ();
      assign ib_push[gi] = fv_s2_q[gi] && !ib_full[gi];
      assign ib_pop[gi] = shift_pop && sel_q == IW'(gi);
      assign ib_flush[gi] = st_q == ST_DROP && sel_q == IW'(gi);
      assign rel[gi] = ib_flush[gi] || (shift_last && sel_q == IW'(gi));
      assign ibf.push = ib_push[gi];
      assign ibf.pop = ib_pop[gi];
      assign ibf.flush = ib_flush[gi];
      assign ibf.din = fd_s2_q[gi];
      assign ib_dout[gi] = ibf.dout;
      assign ib_empty[gi] = ibf.empty;
      assign ib_full[gi] = ibf.full;
      rrf_fifo #(.W(32), .DEPTH(IB_DEPTH)) u_buf (.pclk(pclk), .presetn(presetn), .q(ibf));
    end
    for (gi = 0; gi < NAU; gi++)
    begin : g_of
      rrf_fifo_if #(.W(33)) off ();
      assign of_push[gi] = (shift_pop && tgt_q == 2'(gi)) || close_gnt[gi];
      assign of_din[gi] = close_gnt[gi] ?
        {1'b1, `RRF_REC_NIB, !au_done[gi], 3'h0, au_eid_q[gi]} :
        {1'b0, ib_dout[sel_q]};
      assign tx_go[gi] = !of_empty[gi] &&
        (sending_q[gi] || (!lbp_s2_q[gi] && rec_pend_q[gi]));
      assign jam[gi] = rec_pend_q[gi] && lbp_s2_q[gi];
      assign off.push = of_push[gi];
      assign off.pop = tx_go[gi];
      assign off.flush = 1'b0;
      assign off.din = of_din[gi];
      assign of_dout[gi] = off.dout;
      assign of_empty[gi] = off.empty;
      assign of_full[gi] = off.full;
      rrf_fifo #(.W(33), .DEPTH(OF_DEPTH)) u_out (.pclk(pclk), .presetn(presetn), .q(off));
    end
  endgenerate

  // Fragment framing, event ID capture and backpressure toward the input card.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_d_q <= '0;
      hdr_q <= '0;
      ib_eid_q <= '0;
      rdy_q <= '0;
      frag_bp_q <= '0;
    end
    else
    begin
      full_d_q <= ib_full;
      for (int i = 0; i < NI; i++)
      begin
        if (ib_push[i] && is_nib(fd_s2_q[i], `RRF_HDR_NIB))
          hdr_q[i] <= 1'b1;
        else if (ib_push[i] && hdr_q[i])
        begin
          hdr_q[i] <= 1'b0;
          ib_eid_q[i] <= fd_s2_q[i][EW-1:0];
        end
        if (rel[i])
        begin
          rdy_q[i] <= 1'b0;
          frag_bp_q[i] <= 1'b0;
        end
        // Raising is written last so a new trailer is never lost to a release.
        if ((ib_push[i] && is_nib(fd_s2_q[i], `RRF_TRL_NIB)) || (ib_full[i] && !full_d_q[i]))
        begin
          rdy_q[i] <= 1'b1;
          frag_bp_q[i] <= 1'b1;
        end
      end
    end
  end

  // An input whose fragment sits in an unfinished record may not shift another one.
  always_comb
  begin
    hold = '0;
    for (int a = 0; a < NAU; a++)
      hold = hold | au_mask_q[a];
  end

  // Ownership and target decision for the fragment under the allocator.
  always_comb
  begin
    cur_eid = ib_eid_q[sel_q];
    cmask = (4'h1 << card_q[5:4]) - 4'h1;
    pref = 2'(cur_eid >> card_q[5:4]);
    match_hit = 1'b0;
    match_au = 2'b00;
    free_hit = 1'b0;
    free_au = 2'b00;
    idx = 2'b00;
    for (int a = 0; a < NAU; a++)
    begin
      if (au_busy_q[a] && au_eid_q[a] == cur_eid)
      begin
        match_hit = 1'b1;
        match_au = 2'(a);
      end
    end
    for (int k = 0; k < NAU; k++)
    begin
      idx = pref + 2'(k);
      if (!free_hit && !au_busy_q[idx] && !rec_pend_q[idx] && !jam[idx])
      begin
        free_hit = 1'b1;
        free_au = idx;
      end
    end
    drop = ((cur_eid[3:0] & cmask) != card_q[3:0]) || !active_q[sel_q] ||
           (match_hit && au_mask_q[match_au][sel_q]) ||
           (!match_hit && built_v_q && cur_eid <= built_max_q);
  end

  assign shift_pop = st_q == ST_SHIFT && !ib_empty[sel_q] && !of_full[tgt_q];
  assign shift_last = shift_pop &&
    (is_nib(ib_dout[sel_q], `RRF_TRL_NIB) || cnt_q == IAW'(IB_DEPTH - 1));

  // Allocator sequence.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      sel_q <= '0;
      tgt_q <= 2'b00;
      cnt_q <= '0;
      stall_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (rdy_q[sel_q] && !hold[sel_q])
            st_q <= ST_DECIDE;
          else
            sel_q <= (sel_q == IW'(NI - 1)) ? '0 : sel_q + 1'b1;
        end
        ST_DECIDE:
        begin
          cnt_q <= '0;
          if (drop)
          begin
            st_q <= ST_DROP;
            stall_q <= 1'b0;
          end
          else if (match_hit || free_hit)
          begin
            st_q <= ST_SHIFT;
            tgt_q <= match_hit ? match_au : free_au;
            stall_q <= 1'b0;
          end
          else
          begin
            // No unit free: the fragment keeps its backpressure and is retried.
            st_q <= ST_IDLE;
            stall_q <= 1'b1;
            sel_q <= (sel_q == IW'(NI - 1)) ? '0 : sel_q + 1'b1;
          end
        end
        ST_SHIFT:
        begin
          if (shift_pop)
            cnt_q <= cnt_q + 1'b1;
          if (shift_last)
          begin
            st_q <= ST_IDLE;
            sel_q <= (sel_q == IW'(NI - 1)) ? '0 : sel_q + 1'b1;
          end
        end
        ST_DROP:
        begin
          st_q <= ST_IDLE;
          sel_q <= (sel_q == IW'(NI - 1)) ? '0 : sel_q + 1'b1;
        end
      endcase
    end
  end

  // One record closes per cycle; never while its unit is being fed or decided on.
  always_comb
  begin
    close_gnt = '0;
    au_done = '0;
    for (int a = 0; a < NAU; a++)
    begin
      au_done[a] = (au_mask_q[a] & active_q) == active_q;
      if (au_busy_q[a] && (au_done[a] || au_tmr_q[a] >= timeout_q) &&
          st_q != ST_DECIDE && !(st_q == ST_SHIFT && tgt_q == 2'(a)) &&
          !of_full[a] && close_gnt == '0)
        close_gnt[a] = 1'b1;
    end
  end

  // Assembly unit bookkeeping.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      au_busy_q <= '0;
      au_eid_q <= '0;
      au_mask_q <= '0;
      au_tmr_q <= '0;
      built_max_q <= '0;
      built_v_q <= 1'b0;
    end
    else
    begin
      for (int a = 0; a < NAU; a++)
      begin
        if (close_gnt[a])
        begin
          au_busy_q[a] <= 1'b0;
          au_mask_q[a] <= '0;
          au_tmr_q[a] <= '0;
          built_v_q <= 1'b1;
          if (!built_v_q || au_eid_q[a] > built_max_q)
            built_max_q <= au_eid_q[a];
        end
        else if (au_busy_q[a] && au_tmr_q[a] != '1)
          au_tmr_q[a] <= au_tmr_q[a] + 1'b1;
      end
      if (st_q == ST_DECIDE && !drop && match_hit)
        au_mask_q[match_au][sel_q] <= 1'b1;
      else if (st_q == ST_DECIDE && !drop && free_hit)
      begin
        au_busy_q[free_au] <= 1'b1;
        au_eid_q[free_au] <= cur_eid;
        au_mask_q[free_au] <= NI'(1) << sel_q;
        au_tmr_q[free_au] <= '0;
      end
    end
  end

  // Link transmitters: a started record runs to its end even under backpressure.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lv_q <= '0;
      ll_q <= '0;
      ld_q <= '0;
      sending_q <= '0;
      rec_pend_q <= '0;
    end
    else
    begin
      for (int a = 0; a < NAU; a++)
      begin
        lv_q[a] <= tx_go[a];
        ll_q[a] <= tx_go[a] && of_dout[a][32];
        if (tx_go[a])
        begin
          ld_q[a] <= of_dout[a][31:0];
          sending_q[a] <= !of_dout[a][32];
        end
        if (tx_go[a] && of_dout[a][32])
          rec_pend_q[a] <= 1'b0;
        if (close_gnt[a])
          rec_pend_q[a] <= 1'b1;
      end
    end
  end

  assign frag_bp = frag_bp_q;
  assign link_valid = lv_q;
  assign link_last = ll_q;
  assign link_data = ld_q;

  // APB slave with zero wait states; read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = prdata_q;

  always_comb
  begin
    unique case (paddr)
      `RRF_OFS_CARD: rd_mux = {24'h000000, card_q};
      `RRF_OFS_ACTIVE: rd_mux = 32'(active_q);
      `RRF_OFS_TIMEOUT: rd_mux = 32'(timeout_q);
      `RRF_OFS_STATUS: rd_mux = {3'h0, stall_q, jam, rec_pend_q, au_busy_q, 16'(frag_bp_q)};
      `RRF_OFS_BUILT: rd_mux = {built_v_q, 7'h00, built_max_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (psel && !penable)
      prdata_q <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_q <= `RRF_CARD_RST;
      active_q <= NI'(`RRF_ACTIVE_RST);
      timeout_q <= TW'(`RRF_TIMEOUT_RST);
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `RRF_OFS_CARD)
        card_q <= pwdata[7:0];
      if (paddr == `RRF_OFS_ACTIVE)
        active_q <= pwdata[NI-1:0];
      if (paddr == `RRF_OFS_TIMEOUT)
        timeout_q <= pwdata[TW-1:0];
    end
  end
endmodule

// file: test/rrf_sup_model.sv
// Supervisor link receivers that raise and withdraw link backpressure.
`timescale 1ns/1ps
module rrf_sup_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link side
  input wire logic [3:0] link_valid,
  input wire logic [3:0] link_last,
  output logic [3:0] link_bp,
  // Test control
  input wire logic [3:0] jam,
  input wire logic slow
);
  logic [3:0][3:0] hold_q;

  // A slow receiver stalls as soon as a record starts, so backpressure lands mid-record.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= '0;
    else
      for (int k = 0; k < 4; k++)
        if (hold_q[k] != 4'h0)
          hold_q[k] <= hold_q[k] - 4'h1;
        else if (slow && link_valid[k] && !link_last[k])
          hold_q[k] <= 4'h8;
  end

  assign link_bp = jam | {|hold_q[3], |hold_q[2], |hold_q[1], |hold_q[0]};
endmodule

// file: test/rrf_record_flow_props.sv
// Concurrent checks on the ports of the record flow block.
`timescale 1ns/1ps
module rrf_record_flow_props
  import rrf_pkg::*;
#(
  parameter int NI = 12
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire rrf_pkg::rrf_word_t pwdata,
  input wire rrf_pkg::rrf_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fragments
  input wire logic [NI-1:0] frag_valid,
  input wire rrf_pkg::rrf_word_t [NI-1:0] frag_data,
  input wire logic [NI-1:0] frag_bp,
  // Links
  input wire logic [3:0] link_bp,
  input wire logic [3:0] link_valid,
  input wire logic [3:0] link_last,
  input wire rrf_pkg::rrf_word_t [3:0] link_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [23:0] tmo_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmo_q <= 24'h002710;
    else if (psel && penable && pwrite && paddr == 8'h08)
      tmo_q <= pwdata[23:0];
  end

  chk_ready_high: assert property (psel |-> pready) else $error("pready low");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
  chk_err_unmapped: assert property (psel && penable && paddr > 8'h10 |-> pslverr && prdata == 0)
    else $error("unmapped not refused");
  chk_timeout_readback: assert property (psel && penable && !pwrite && paddr == 8'h08 |->
    prdata[23:0] == tmo_q) else $error("timeout readback");
  chk_last_in_word: assert property ((link_last & ~link_valid) == 4'h0) else $error("last alone");
  chk_reset_quiet: assert property (disable iff (1'b0) !presetn |-> link_valid == 4'h0 &&
    frag_bp == '0) else $error("active in reset");
  for (genvar k = 0; k < 4; k++)
  begin : g_link
    chk_tag_form: assert property (link_last[k] |-> link_data[k][31:28] == 4'hc &&
      link_data[k][26:24] == 3'b000) else $error("bad tag word");
    chk_record_whole: assert property (link_valid[k] && !link_last[k] |=> link_valid[k])
      else $error("record cut");
    chk_link_hold: assert property (link_bp[k] [*6] ##0 !link_valid[k] |=> !link_valid[k])
      else $error("sent under backpressure");
  end
  for (genvar i = 0; i < NI; i++)
  begin : g_in
    chk_trailer_bp: assert property (frag_valid[i] && frag_data[i][31:28] == 4'he |->
      ##[1:3] frag_bp[i]) else $error("no input backpressure");
  end
  cover property (psel && penable && pslverr);
  cover property (|(link_bp & link_valid));
  cover property (|(link_last & {link_data[3][27], link_data[2][27], link_data[1][27],
    link_data[0][27]}));
endmodule

bind rrf_record_flow rrf_record_flow_props #(.NI(NI)) i_rrf_record_flow_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frag_valid(frag_valid), .frag_data(frag_data), .frag_bp(frag_bp), .link_bp(link_bp),
  .link_valid(link_valid), .link_last(link_last), .link_data(link_data)
);

// file: test/rrf_record_flow_test.sv
// Self-checking bench for the record flow block with supervisor link models.
`timescale 1ns/1ps
module rrf_record_flow_test;
  import rrf_pkg::*;
  typedef struct {rrf_word_t tag; int n;} rrf_exp_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, slow;
  logic [7:0] paddr;
  rrf_word_t pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic [11:0] frag_valid, frag_bp;
  rrf_word_t [11:0] frag_data;
  logic [3:0] link_bp, link_valid, link_last, jam;
  rrf_word_t [3:0] link_data;
  rrf_word_t rst_tab [5] = '{32'h0, 32'h0fff, 32'h002710, 32'h0, 32'h0};
  rrf_exp_t exp_q [$];
  rrf_exp_t e, held;
  int fails = 0;
  int total_checks = 0;
  int seed = 7271;
  int words_seen [4] = '{0, 0, 0, 0};

  always #50 pclk = ~pclk;

  rrf_record_flow #(.IB_DEPTH(16), .OF_DEPTH(64)) i_rrf_record_flow
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frag_valid(frag_valid), .frag_data(frag_data), .frag_bp(frag_bp), .link_bp(link_bp),
    .link_valid(link_valid), .link_last(link_last), .link_data(link_data)
  );
  rrf_sup_model i_rrf_sup_model
  (
    .pclk(pclk), .presetn(presetn), .link_valid(link_valid), .link_last(link_last),
    .link_bp(link_bp), .jam(jam), .slow(slow)
  );

  task automatic chk_reg(input rrf_word_t got, input rrf_word_t exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t reg %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rec(input rrf_word_t tag, input int n, input rrf_exp_t x);
    total_checks++;
    if (tag !== x.tag || n != x.n)
    begin
      fails++;
      $display("[ERR] %0t rec %h/%h exp %h/%h", $time, tag, n, x.tag, x.n);
    end
  endtask

  task give_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input rrf_word_t d,
    output rrf_word_t r, output logic x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The input card only starts a fragment while this card shows no backpressure.
  task automatic send_frag(input int i, input logic [23:0] eid, input int n);
    rrf_word_t r;
    while (frag_bp[i] !== 1'b0)
      @(posedge pclk);
    for (int w = 0; w < n; w++)
    begin
      @(posedge pclk);
      r = $random(seed);
      frag_valid[i] <= 1'b1;
      frag_data[i] <= (w == 0) ? {4'hb, r[27:0]} : (w == 1) ? {4'h2, r[3:0], eid} :
        (w == n - 1) ? {4'he, r[27:0]} : {4'h1, r[27:0]};
    end
    @(posedge pclk);
    frag_valid[i] <= 1'b0;
  endtask

  // Lengths are drawn first so the note is queued before any word can leave.
  task automatic ev(input logic [23:0] eid, input int m, input bit inc, input bit note,
    output rrf_exp_t x);
    int n [2];
    x.n = 1;
    for (int i = 0; i < m; i++)
    begin
      n[i] = 3 + $unsigned($random(seed)) % 4;
      x.n += n[i];
    end
    x.tag = {4'hc, inc, 3'b000, eid};
    if (note)
      exp_q.push_back(x);
    for (int i = 0; i < m; i++)
      send_frag(i, eid, n[i]);
  endtask

  task automatic drain;
    int t;
    t = 0;
    while (exp_q.size() != 0 && t < 2000)
    begin
      @(posedge pclk);
      t++;
    end
    repeat (5) @(posedge pclk);
    chk_reg(32'(exp_q.size()), 32'h0);
  endtask

  always @(posedge pclk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (link_valid[k] === 1'b1 && words_seen[k] == 0)
        chk_reg({28'h0, link_data[k][31:28]}, 32'h0000000b);
      if (link_valid[k] === 1'b1)
        words_seen[k]++;
      if (link_last[k] === 1'b1)
      begin
        if (exp_q.size() == 0)
          chk_reg(link_data[k], 32'h0);
        else
          chk_rec(link_data[k], words_seen[k], exp_q.pop_front());
        words_seen[k] = 0;
      end
    end
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, frag_valid, frag_data, jam, slow} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0, rd, er);
      chk_reg(rd, rst_tab[k]);
    end
    apb(1'b1, 8'h14, 32'hffffffff, rd, er);
    chk_reg({31'h0, er}, 32'h1);
    apb(1'b1, 8'h0c, 32'hffffffff, rd, er);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk_reg(rd, 32'h0);
    apb(1'b1, 8'h08, 32'd50, rd, er);
    apb(1'b1, 8'h04, 32'h3, rd, er);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk_reg(rd, 32'd50);
    for (int k = 0; k < 4; k++)
    begin
      slow <= (k > 1);
      ev(24'(32'h10 + k), 2, 1'b0, 1'b1, e);
      drain();
    end
    slow <= 1'b0;
    ev(24'h20, 1, 1'b1, 1'b1, e);
    drain();
    send_frag(1, 24'h20, 4);
    repeat (60) @(posedge pclk);
    chk_reg({20'h0, frag_bp}, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk_reg(rd, 32'h80000020);
    // Two cards share the events, so only even ones are built here.
    apb(1'b1, 8'h00, 32'h10, rd, er);
    ev(24'h21, 2, 1'b0, 1'b0, e);
    // The allocator may need a whole lap over the inputs before it reaches the last one.
    repeat (40) @(posedge pclk);
    chk_reg({20'h0, frag_bp}, 32'h0);
    ev(24'h22, 2, 1'b0, 1'b1, e);
    drain();
    apb(1'b1, 8'h00, 32'h0, rd, er);
    jam <= 4'h8;
    ev(24'h23, 2, 1'b0, 1'b0, held);
    repeat (40) @(posedge pclk);
    ev(24'h27, 2, 1'b0, 1'b1, e);
    drain();
    exp_q.push_back(held);
    jam <= 4'h0;
    drain();
    give_verdict();
  end
endmodule
